// file: i2c_adc_read_slave.sv
// two-wire read slave of the 10-bit converter: bus decode and shifter
`include "i2c_adc_cfg.svh"

module i2c_adc_read_slave #(
  parameter logic [3:0] DEVICE_CODE  = `DEVICE_CODE_DEFAULT, // value arbitrary
  parameter logic [2:0] ADDR_OPTION  = `ADDR_OPTION_DEFAULT,
  parameter int         RESULT_WIDTH = `RESULT_WIDTH,
  parameter int         BUF_DEPTH    = `BUF_DEPTH,
  parameter int         ACQ_CYCLES   =
    int'($ceil(`ACQ_TIME_US * 1000.0 / `CLK_PERIOD_NS)),
  parameter int         CONV_CYCLES  =
    int'($ceil(`CONV_TIME_US * 1000.0 / `CLK_PERIOD_NS))
) (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    sclIn,
  input  wire logic                    sdaIn,
  output logic                         sdaOut,
  output logic                         sdaOe,
  input  wire logic [RESULT_WIDTH-1:0] analogInput,
  output logic      [RESULT_WIDTH-1:0] resultValue,
  output logic                         convBusy
);
  // refuse widths the byte format cannot serve; phase lengths are checked in the sequencer
  if (RESULT_WIDTH != 10)
  begin
    $error("the two-byte result format holds exactly ten bits");
  end

  // bus line synchronisers and edge history
  logic sclMeta;
  logic sclSync;
  logic sclPrev;
  logic sdaMeta;
  logic sdaSync;
  logic sdaPrev;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclMeta <= 1'b1;
      sclSync <= 1'b1;
      sclPrev <= 1'b1;
      sdaMeta <= 1'b1;
      sdaSync <= 1'b1;
      sdaPrev <= 1'b1;
    end
    else
    begin
      sclMeta <= sclIn;
      sclSync <= sclMeta;
      sclPrev <= sclSync;
      sdaMeta <= sdaIn;
      sdaSync <= sdaMeta;
      sdaPrev <= sdaSync;
    end
  end

  // bus events seen after synchronisation
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;

  assign sclRise  = sclSync && !sclPrev;
  assign sclFall  = !sclSync && sclPrev;
  assign startDet = sclSync && sclPrev && sdaPrev && !sdaSync;
  assign stopDet  = sclSync && sclPrev && !sdaPrev && sdaSync;

  // slave state
  i2c_adc_pkg::slave_state_t state;
  i2c_adc_pkg::slave_state_t next_state;
  logic [3:0]                bitCnt;
  logic [3:0]                next_bitCnt;
  logic [7:0]                shiftReg;
  logic [7:0]                next_shiftReg;
  logic                      rwBit;
  logic                      next_rwBit;
  logic                      byteSel;
  logic                      next_byteSel;
  logic                      ackSeen;
  logic                      next_ackSeen;
  logic                      next_sdaOe;
  logic [RESULT_WIDTH-1:0]   txWord;
  logic [RESULT_WIDTH-1:0]   next_txWord;
  logic                      txLock;
  logic                      next_txLock;
  logic                      convStart;
  logic                      addrMatch;

  // seven address bits against the fixed code and option bits
  assign addrMatch = shiftReg[7:1] == {DEVICE_CODE, ADDR_OPTION};
  // one bit of the outgoing byte pair, most significant first
  function automatic logic txBit(input logic sel, input logic [2:0] idx,
                                 input logic [9:0] word);
    logic [7:0] frame;
    frame = sel ? {word[5:0], 2'b00} : {4'h0, word[9:6]};
    return frame[3'd7 - idx];
  endfunction

  // bus protocol next-state logic
  always_comb
  begin
    next_state    = state;
    next_bitCnt   = bitCnt;
    next_shiftReg = shiftReg;
    next_rwBit    = rwBit;
    next_byteSel  = byteSel;
    next_ackSeen  = ackSeen;
    next_sdaOe    = sdaOe;
    next_txWord   = txWord;
    next_txLock   = txLock;
    convStart     = 1'b0;
    if (startDet)
    begin
      next_state  = i2c_adc_pkg::stAddr;
      next_bitCnt = 4'h0;
      next_sdaOe  = 1'b0;
      next_txLock = 1'b0;
    end
    else if (stopDet)
    begin
      next_state  = i2c_adc_pkg::stIdle;
      next_sdaOe  = 1'b0;
      next_txLock = 1'b0;
    end
    else
    begin
      case (state)
        i2c_adc_pkg::stIdle:
          next_sdaOe = 1'b0;
        i2c_adc_pkg::stAddr:
        begin
          if (sclRise)
          begin
            next_shiftReg = {shiftReg[6:0], sdaSync};
            next_bitCnt   = bitCnt + 4'h1;
          end
          if (sclFall && bitCnt == `ADDR_BITS)
          begin
            if (addrMatch)
            begin
              next_state = i2c_adc_pkg::stAddrAck;
              next_sdaOe = 1'b1;
              next_rwBit = shiftReg[0];
              convStart  = shiftReg[0];
            end
            else
              next_state = i2c_adc_pkg::stIdle;
          end
        end
        i2c_adc_pkg::stAddrAck:
          if (sclFall)
          begin
            if (rwBit)
            begin
              next_state   = i2c_adc_pkg::stTx;
              next_byteSel = 1'b0;
              next_bitCnt  = 4'h0;
              next_sdaOe   = 1'b1; // first zero bit
            end
            else
            begin
              next_state = i2c_adc_pkg::stIdle;
              next_sdaOe = 1'b0;
            end
          end
        i2c_adc_pkg::stTx:
          if (sclFall)
          begin
            next_bitCnt = bitCnt + 4'h1;
            if (bitCnt == `LAST_DATA_BIT)
            begin
              next_state = i2c_adc_pkg::stTxAck;
              next_sdaOe = 1'b0; // let the master answer
              if (byteSel)
              begin
                convStart   = 1'b1;
                next_txLock = 1'b0;
              end
            end
            else if (!byteSel && bitCnt == `ZERO_NIBBLE_LAST)
            begin
              next_txWord = resultValue;
              next_txLock = 1'b1;
              next_sdaOe  = !txBit(1'b0, 3'(bitCnt + 4'h1), resultValue);
            end
            else
              next_sdaOe = !txBit(byteSel, 3'(bitCnt + 4'h1), txWord);
          end
        i2c_adc_pkg::stTxAck:
        begin
          if (sclRise)
            next_ackSeen = !sdaSync;
          if (sclFall)
          begin
            if (ackSeen)
            begin
              next_state   = i2c_adc_pkg::stTx;
              next_byteSel = !byteSel;
              next_bitCnt  = 4'h0;
              next_sdaOe   = byteSel ? 1'b1 : !txWord[5];
            end
            else
              next_state = i2c_adc_pkg::stIdle;
          end
        end
        default:
          next_state = i2c_adc_pkg::stIdle;
      endcase
    end
  end

  // bus protocol registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state    <= i2c_adc_pkg::stIdle;
      bitCnt   <= 4'h0;
      shiftReg <= 8'h00;
      rwBit    <= 1'b0;
      byteSel  <= 1'b0;
      ackSeen  <= 1'b0;
      sdaOe    <= 1'b0;
      txWord   <= '0;
      txLock   <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      bitCnt   <= next_bitCnt;
      shiftReg <= next_shiftReg;
      rwBit    <= next_rwBit;
      byteSel  <= next_byteSel;
      ackSeen  <= next_ackSeen;
      sdaOe    <= next_sdaOe;
      txWord   <= next_txWord;
      txLock   <= next_txLock;
    end
  end

  // open drain: the pad only ever pulls low
  assign sdaOut = 1'b0;
  // converter, buffer and result register
  logic                    seqValid;
  logic                    seqReady;
  logic [RESULT_WIDTH-1:0] seqData;
  logic                    bufValid;
  logic [RESULT_WIDTH-1:0] bufData;
  logic [RESULT_WIDTH-1:0] next_resultValue;
  conv_sequencer #(
    .WIDTH       (RESULT_WIDTH),
    .ACQ_CYCLES  (ACQ_CYCLES),
    .CONV_CYCLES (CONV_CYCLES)
  ) u_seq (
    .clk         (clk),
    .nrst        (nrst),
    .convStart   (convStart),
    .analogInput (analogInput),
    .busy        (convBusy),
    .outValid    (seqValid),
    .outReady    (seqReady),
    .outData     (seqData)
  );
  result_buffer #(
    .WIDTH (RESULT_WIDTH),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk     (clk),
    .nrst    (nrst),
    .wrValid (seqValid),
    .wrReady (seqReady),
    .wrData  (seqData),
    .rdValid (bufValid),
    .rdReady (!txLock),
    .rdData  (bufData)
  );
  // newest result replaces the old one unless a word is in flight
  always_comb
  begin
    next_resultValue = resultValue;
    if (bufValid && !txLock)
      next_resultValue = bufData;
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      resultValue <= '0;
    else
      resultValue <= next_resultValue;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_start_addr: assert property (startDet |=> state == i2c_adc_pkg::stAddr)
    else $error("start did not open address phase");
  a_stop_idle: assert property (
    stopDet && !startDet |=> state == i2c_adc_pkg::stIdle && !sdaOe)
    else $error("stop did not return to idle");
  a_ack_drive: assert property (
    state == i2c_adc_pkg::stAddrAck |-> sdaOe)
    else $error("address acknowledge not driven low");
  a_read_conv: assert property (
    state == i2c_adc_pkg::stAddr && sclFall && bitCnt == `ADDR_BITS && addrMatch
      && shiftReg[0] |-> convStart ##1 convBusy)
    else $error("matching read did not start conversion");
  a_poll_release: assert property (
    state == i2c_adc_pkg::stAddrAck && sclFall && !rwBit && !startDet && !stopDet
      |-> !convStart ##1 (state == i2c_adc_pkg::stIdle && !sdaOe))
    else $error("poll did not release the bus");
  a_mismatch_ignore: assert property (
    state == i2c_adc_pkg::stAddr && sclFall && bitCnt == `ADDR_BITS && !addrMatch
      && !startDet && !stopDet |=> (state == i2c_adc_pkg::stIdle) [*2])
    else $error("non-matching address not ignored");
  a_zero_nibble: assert property (
    state == i2c_adc_pkg::stTx && !byteSel && bitCnt <= `ZERO_NIBBLE_LAST |-> sdaOe)
    else $error("leading zero bits not sent");
  a_nak_release: assert property (
    state == i2c_adc_pkg::stTxAck && sclFall && !ackSeen && !startDet && !stopDet
      |=> state == i2c_adc_pkg::stIdle && !sdaOe)
    else $error("device kept the bus after a refusal");
  a_stable_high: assert property (
    state == i2c_adc_pkg::stTx && sclSync && sclPrev && !startDet && !stopDet
      |-> $stable(sdaOe))
    else $error("data changed while clock high");
  a_cont_sample: assert property (
    state == i2c_adc_pkg::stTx && byteSel && sclFall && bitCnt == `LAST_DATA_BIT
      && !startDet && !stopDet |-> convStart)
    else $error("continuous sampling did not start");
  c_read_done: cover property (state == i2c_adc_pkg::stTxAck && byteSel && sclFall);
  c_poll: cover property (state == i2c_adc_pkg::stAddrAck && !rwBit && sclFall);
  c_continuous: cover property (convStart && state == i2c_adc_pkg::stTx);
  c_mismatch: cover property (state == i2c_adc_pkg::stAddr && sclFall
                              && bitCnt == `ADDR_BITS && !addrMatch);
endmodule

// file: i2c_adc_cfg.svh
// constants for the two-wire converter read slave
// Operation
// - keep latest 10-bit result, readable anytime
// - own oscillator times acquisition and conversion
// - send unsigned binary result, MSB first
// - conversion phase lasts 8.96 us
// - acquisition phase lasts 1.12 us
// - continuous period is 18 serial clocks
// - sustain 22.3 ksps at 400 kHz
// - SDA falling while SCL high is START
// - SDA rising while SCL high is STOP
// - change data only while clock low
// - receiver pulls SDA low on ninth clock
// - master NAK ends read, device releases
// - seven address bits must match exactly
// - address option bits default to 101
// - read bit set: acknowledge, convert, return
// - read bit clear: acknowledge, release, no conversion
// - zeros plus upper nibble, then lower six bits
// - sampling starts at read bit falling edge
// - next sampling starts on last lower bit
`ifndef I2C_ADC_CFG_SVH
`define I2C_ADC_CFG_SVH
`define RESULT_WIDTH 10
`define ADDR_OPTION_DEFAULT 3'b101
`define DEVICE_CODE_DEFAULT 4'h6
`define BUF_DEPTH 2
`define CLK_PERIOD_NS 4.0
`define ACQ_TIME_US 1.12
`define CONV_TIME_US 8.96
`define FAST_SCL_KHZ 400.0
`define MAX_RATE_KSPS 22.3
`define CONT_PERIOD_CLOCKS 18
`define ADDR_BITS 4'h8
`define ZERO_NIBBLE_LAST 4'h3
`define LAST_DATA_BIT 4'h7
`endif

// file: i2c_adc_pkg.sv
// state types of the two-wire converter read slave
package i2c_adc_pkg;
  typedef enum logic [2:0] {stIdle, stAddr, stAddrAck, stTx, stTxAck} slave_state_t;
  typedef enum logic [1:0] {sqIdle, sqAcq, sqConv, sqPush} seq_state_t;
endpackage

// file: result_buffer.sv
// small first-in first-out buffer between converter and shifter
module result_buffer #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             wrValid,
  output logic                  wrReady,
  input  wire logic [WIDTH-1:0] wrData,
  output logic                  rdValid,
  input  wire logic             rdReady,
  output logic      [WIDTH-1:0] rdData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin
    $error("buffer depth must be a power of two, at least two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      fill;
  logic [AW-1:0]    next_wrPtr;
  logic [AW-1:0]    next_rdPtr;
  logic [AW:0]      next_fill;
  logic             push;
  logic             pop;

  // honest full and empty from the fill count
  assign wrReady = fill != (AW+1)'(DEPTH);
  assign rdValid = fill != '0;
  assign rdData  = mem[rdPtr];
  assign push    = wrValid && wrReady;
  assign pop     = rdValid && rdReady;

  // pointer and fill update
  always_comb
  begin
    next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
    next_fill  = fill + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      fill  <= '0;
    end
    else
    begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      fill  <= next_fill;
    end
  end

  // storage needs no reset
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wrPtr] <= wrData;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_fill_count: assert property (push && !pop |=> fill == $past(fill) + 1'b1)
    else $error("buffer fill did not grow on a lone push");
  c_buffer_full: cover property (fill == (AW+1)'(DEPTH) && wrValid);
endmodule

// file: conv_sequencer.sv
// self-timed acquisition and conversion sequencer
`include "i2c_adc_cfg.svh"

module conv_sequencer #(
  parameter int WIDTH       = 10,
  parameter int ACQ_CYCLES  = 280,
  parameter int CONV_CYCLES = 2240
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             convStart,
  input  wire logic [WIDTH-1:0] analogInput,
  output logic                  busy,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int MAXC = (ACQ_CYCLES > CONV_CYCLES) ? ACQ_CYCLES : CONV_CYCLES;
  localparam int CW   = $clog2(MAXC) + 1;

  // refuse phase lengths the down counters or the bus rate cannot serve
  if (ACQ_CYCLES < 1 || CONV_CYCLES < 1)
  begin
    $error("both phases must last at least one clock");
  end

  if ((ACQ_CYCLES + CONV_CYCLES) * `CLK_PERIOD_NS >
      `CONT_PERIOD_CLOCKS * 1.0e6 / `FAST_SCL_KHZ)
  begin
    $error("conversion does not fit one continuous period");
  end

  if ((ACQ_CYCLES + CONV_CYCLES) * `CLK_PERIOD_NS > 1.0e6 / `MAX_RATE_KSPS)
  begin
    $error("conversion too slow for the top sample rate");
  end

  i2c_adc_pkg::seq_state_t stage;
  i2c_adc_pkg::seq_state_t next_stage;
  logic [CW-1:0]           cnt;
  logic [CW-1:0]           next_cnt;
  logic [WIDTH-1:0]        next_outData;
  int unsigned             elapsed;

  // phases counted on the internal clock only, never on SCL
  always_comb
  begin
    next_stage   = stage;
    next_cnt     = cnt;
    next_outData = outData;
    case (stage)
      i2c_adc_pkg::sqIdle:
        if (convStart)
        begin
          next_stage = i2c_adc_pkg::sqAcq;
          next_cnt   = CW'(ACQ_CYCLES - 1);
        end
      i2c_adc_pkg::sqAcq:
        if (cnt == '0)
        begin
          next_outData = analogInput; // hold capacitor disconnects here
          next_stage   = i2c_adc_pkg::sqConv;
          next_cnt     = CW'(CONV_CYCLES - 1);
        end
        else
          next_cnt = cnt - 1'b1;
      i2c_adc_pkg::sqConv:
        if (cnt == '0)
          next_stage = i2c_adc_pkg::sqPush;
        else
          next_cnt = cnt - 1'b1;
      i2c_adc_pkg::sqPush:
        if (outReady)
          next_stage = i2c_adc_pkg::sqIdle; // stalls while the buffer is full
      default:
        next_stage = i2c_adc_pkg::sqIdle;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage   <= i2c_adc_pkg::sqIdle;
      cnt     <= '0;
      outData <= '0;
    end
    else
    begin
      stage   <= next_stage;
      cnt     <= next_cnt;
      outData <= next_outData;
    end
  end

  assign busy     = stage != i2c_adc_pkg::sqIdle;
  assign outValid = stage == i2c_adc_pkg::sqPush;

  // elapsed cycles since start, for the duration check
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      elapsed <= 0;
    else if (stage == i2c_adc_pkg::sqIdle)
      elapsed <= 0;
    else if (stage != i2c_adc_pkg::sqPush)
      elapsed <= elapsed + 1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_phase_duration: assert property (
    $rose(stage == i2c_adc_pkg::sqPush) |-> elapsed == ACQ_CYCLES + CONV_CYCLES)
    else $error("acquisition plus conversion time is wrong");
endmodule

// file: i2c_master_model.sv
// two-wire bus master model that drives the converter read slave
module i2c_master_model (
  input  wire logic clk,
  input  wire logic sdaBus,
  output logic      scl,
  output logic      sdaDrv
);
  timeunit 1ns;
  timeprecision 100ps;

  // both lines released at rest; the clock stands still between frames
  initial
  begin
    scl    = 1'b1;
    sdaDrv = 1'b1;
  end

  // wait whole system clocks, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // data falls while the clock is high; also serves as a repeated start
  task automatic start();
    sdaDrv = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sdaDrv = 1'b0;
    tick(4);
    scl = 1'b0;
    tick(4);
  endtask

  // data rises while the clock is high, then the bus rests
  task automatic stop();
    sdaDrv = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sdaDrv = 1'b1;
    tick(8);
  endtask

  // one pulse per bit: data set in the low phase, sampled mid-high
  task automatic clkBit(input logic b, output logic got);
    sdaDrv = b;
    tick(4);
    scl = 1'b1;
    tick(4);
    got = sdaBus;
    tick(4);
    scl = 1'b0;
    tick(4);
  endtask

  // eight bits then the acknowledge pulse; a released line reads back high
  task automatic xfer(input  logic [7:0] wr,
                      input  logic       ackIn,
                      output logic [7:0] rd,
                      output logic       ackOut);
    for (int i = 7; i >= 0; i--)
      clkBit(wr[i], rd[i]);
    clkBit(ackIn, ackOut);
  endtask
endmodule

// file: i2c_adc_read_slave_tb.sv
// self-checking bench of the converter read slave against a bus master model
`define CHK(got, exp) \
  begin \
    samplesChecked++; \
    if ((got) !== (exp)) \
    begin \
      errTotal++; \
      $display("ERROR %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module i2c_adc_read_slave_tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [3:0] DEV_CODE = 4'h6; // value arbitrary
  localparam logic [7:0] RD_ADDR  = {DEV_CODE, 3'b101, 1'b1};

  typedef struct {
    logic [7:0] addrByte;
    logic [9:0] value;
    logic       expAck;
    logic       expBusy;
  } row_t;

  logic       clk;
  logic       nrst;
  logic       scl;
  logic       sdaDrv;
  logic       sdaBus;
  logic       sdaOut;
  logic       sdaOe;
  logic [9:0] analogIn;
  logic [9:0] resultValue;
  logic       convBusy;
  logic [9:0] lastVal;
  logic       sclPrev;
  logic       oePrev;
  logic [7:0] rd;
  logic       ack;
  int         errTotal;
  int         samplesChecked;

  // ordinary cases: address byte, input value, acknowledge and busy expected
  row_t rows [7] = '{
    '{RD_ADDR, 10'h3ff, 1'b0, 1'b1},
    '{RD_ADDR, 10'h000, 1'b0, 1'b1},
    '{RD_ADDR, 10'h2a5, 1'b0, 1'b1},
    '{{DEV_CODE, 3'b101, 1'b0}, 10'h155, 1'b0, 1'b0},
    '{{DEV_CODE ^ 4'h1, 3'b101, 1'b1}, 10'h0aa, 1'b1, 1'b0},
    '{{DEV_CODE, 3'b100, 1'b1}, 10'h0aa, 1'b1, 1'b0},
    '{{DEV_CODE, 3'b001, 1'b1}, 10'h0aa, 1'b1, 1'b0}
  };

  // open-drain data wire with pull-up
  assign sdaBus = sdaOe ? (sdaOut & sdaDrv) : sdaDrv;

  i2c_adc_read_slave #(
    .DEVICE_CODE (DEV_CODE),
    .ACQ_CYCLES  (8),
    .CONV_CYCLES (24)
  ) u_dut (
    .clk         (clk),
    .nrst        (nrst),
    .sclIn       (scl),
    .sdaIn       (sdaBus),
    .sdaOut      (sdaOut),
    .sdaOe       (sdaOe),
    .analogInput (analogIn),
    .resultValue (resultValue),
    .convBusy    (convBusy)
  );

  i2c_master_model u_master (
    .clk    (clk),
    .sdaBus (sdaBus),
    .scl    (scl),
    .sdaDrv (sdaDrv)
  );

  // system clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // the device may move the data line only while the clock is low
  always @(posedge clk)
  begin
    if (nrst && scl && sclPrev && sdaOe !== oePrev)
      `CHK(sdaOe, oePrev)
    sclPrev <= scl;
    oePrev  <= sdaOe;
  end

  task automatic summarize();
    if (errTotal == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // two result bytes; the input moves to nextV before the last lower bit
  task automatic readPair(input logic [9:0] v, input logic [9:0] nextV, input logic lastAck);
    logic [7:0] b0;
    logic [7:0] b1;
    logic       a;
    u_master.xfer(8'hff, 1'b0, b0, a);
    analogIn = nextV;
    u_master.xfer(8'hff, lastAck, b1, a);
    `CHK(b0, {4'h0, v[9:6]})
    `CHK(b1[7:2], v[5:0])
  endtask

  // one addressed frame closed by a stop
  task automatic runRow(input row_t r);
    analogIn = r.value;
    u_master.start();
    u_master.xfer(r.addrByte, 1'b1, rd, ack);
    `CHK(ack, r.expAck)
    `CHK(convBusy, r.expBusy)
    if (r.expBusy)
    begin
      readPair(r.value, r.value, 1'b1);
      lastVal = r.value;
    end
    else
    begin
      u_master.xfer(8'hff, 1'b1, rd, ack);
      `CHK(rd, 8'hff)
    end
    u_master.stop();
    `CHK(resultValue, lastVal)
    `CHK(sdaOut, 1'b0)
  endtask

  // watchdog sized well above the expected run
  initial
  begin
    repeat (60000) @(posedge clk);
    errTotal++;
    summarize();
  end

  initial
  begin
    nrst     = 1'b0;
    analogIn = 10'h000;
    lastVal  = 10'h000;
    errTotal = 0;
    samplesChecked = 0;
    repeat (8) @(posedge clk);
    #1;
    `CHK(sdaOe, 1'b0)
    `CHK(resultValue, 10'h000)
    `CHK(convBusy, 1'b0)
    nrst = 1'b1;
    u_master.tick(8);
    foreach (rows[i])
      runRow(rows[i]);
    // continuous mode: master acknowledges the lower byte for a new sample
    analogIn = 10'h0f0;
    u_master.start();
    u_master.xfer(RD_ADDR, 1'b1, rd, ack);
    readPair(10'h0f0, 10'h30f, 1'b0);
    `CHK(convBusy, 1'b1)
    readPair(10'h30f, 10'h30f, 1'b1);
    u_master.stop();
    `CHK(resultValue, 10'h30f)
    // stop in mid-byte drops the device; further clocks are ignored
    analogIn = 10'h3ff;
    u_master.start();
    u_master.xfer(RD_ADDR, 1'b1, rd, ack);
    u_master.xfer(8'hff, 1'b0, rd, ack);
    u_master.clkBit(1'b1, ack);
    u_master.clkBit(1'b1, ack);
    u_master.stop();
    u_master.xfer(8'hff, 1'b1, rd, ack);
    `CHK(rd, 8'hff)
    `CHK(ack, 1'b1)
    u_master.stop();
    // reset during a conversion, then a clean frame
    u_master.start();
    u_master.xfer(RD_ADDR, 1'b1, rd, ack);
    nrst = 1'b0;
    u_master.tick(2);
    `CHK(sdaOe, 1'b0)
    `CHK(convBusy, 1'b0)
    `CHK(resultValue, 10'h000)
    nrst = 1'b1;
    lastVal = 10'h000;
    u_master.stop();
    runRow(rows[2]);
    summarize();
  end
endmodule
